// ### src/tcr_map.svh
// register offsets, field positions, reset values for the timer register block
// assumes a 6-bit I/O address space with byte-wide registers
`ifndef TCR_MAP_SVH
`define TCR_MAP_SVH
`define TCR_CAPTURE_LOW   6'h22
`define TCR_CAPTURE_HIGH  6'h23
`define TCR_CMP_B_LOW     6'h24
`define TCR_CMP_B_HIGH    6'h25
`define TCR_CMP_A_LOW     6'h26
`define TCR_CMP_A_HIGH    6'h27
`define TCR_COUNT_LOW     6'h28
`define TCR_COUNT_HIGH    6'h29
`define TCR_FLAGS         6'h2A
`define TCR_MASK          6'h2B
`define TCR_FORCE         6'h2C
`define TCR_FORCE_A_BIT   7
`define TCR_FORCE_B_BIT   6
`define TCR_CAPTURE_BIT   5
`define TCR_CMP_B_BIT     2
`define TCR_CMP_A_BIT     1
`define TCR_OVF_BIT       0
`define TCR_EVENT_MASK    8'h27
`define TCR_RESET_BYTE    8'h00
`define TCR_RESET_WORD    16'h0000
`endif

// ### src/tcr_pkg.sv
// types shared by the timer register block
// assumes nothing beyond a SystemVerilog compiler
package tcr_pkg;
  typedef logic [7:0]  tcr_byte_t;
  typedef logic [15:0] tcr_word_t;
  typedef logic [3:0]  tcr_mode_t;
  typedef logic [1:0]  tcr_action_t;
endpackage

// ### src/tcr_regs.sv
// register side of a 16-bit timer/counter: counter, compares, capture,
// shared high-byte latch, force strobes, mask and event flags
// assumes timer_tick_i is a one-cycle enable at the selected timer rate
// and that waveform decoding, prescaler and capture edge logic sit outside
// How it works
// RULE1 - force strobes honoured only in non-PWM waveform modes
// RULE2 - force strobe gives an immediate compare match event for its channel
// RULE3 - forced match carries the output action field present at the strobe
// RULE4 - forced match sets no flag and never clears the counter
// RULE5 - force bits always read back as zero
// RULE6 - each 16-bit value is a high byte 15:8 and low byte 7:0
// RULE7 - counter bytes give direct read and write of the live counter
// RULE8 - one 8-bit high-byte latch serves every 16-bit register
// RULE9 - high byte written first into latch; low write commits; low read loads latch
// RULE10 - a counter write suppresses all compare matches on the next timer tick
// RULE11 - software should not change a running counter or matches may be missed
// RULE12 - compare values are checked against the counter on every tick
// RULE13 - a capture event copies the counter into the capture register
// RULE14 - capture register can serve as counter top in modes that select it
// RULE15 - capture request is enable bit 5 and global enable and capture flag
// RULE16 - compare B request is enable bit 2 and global enable and its flag
// RULE17 - compare A request is enable bit 1 and global enable and its flag
// RULE18 - overflow request is enable bit 0 and global enable and its flag
// RULE19 - compare flag set at the tick where counter equals compare value
// RULE20 - flags clear on vector acknowledge or by writing one to them
// RULE21 - with capture as top, capture flag sets when counter reaches top
// RULE22 - with capture as top, capture events are ignored
`include "tcr_map.svh"
`timescale 1ns/1ns
`default_nettype none

module tcr_regs
  import tcr_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic        clk_i,                // io clock, 100 MHz
  input  wire logic        reset_n_i,            // async reset, active low
  input  wire logic [5:0]  io_addr_i,            // io register address
  input  wire logic        io_wr_i,              // write strobe
  input  wire logic        io_rd_i,              // read strobe
  input  wire logic [7:0]  io_wdata_i,           // write data
  output logic      [7:0]  io_rdata_o,           // read data, one cycle later
  input  wire logic        timer_tick_i,         // selected timer clock enable
  input  wire logic [3:0]  waveform_mode_select_i, // mode from control regs
  input  wire logic [1:0]  compare_output_action_a_i, // channel a action
  input  wire logic [1:0]  compare_output_action_b_i, // channel b action
  input  wire logic        count_clear_i,        // waveform unit clears at top
  input  wire logic        count_down_i,         // waveform unit counts down
  input  wire logic        overflow_event_i,     // overflow condition pulse
  input  wire logic        capture_event_i,      // edge from capture front end
  input  wire logic        global_irq_enable_i,  // cpu global interrupt flag
  input  wire logic [3:0]  irq_ack_i,            // vector taken: cap,b,a,ovf
  output logic      [15:0] counter_value_o,      // live counter
  output logic      [15:0] compare_a_value_o,    // compare a value
  output logic      [15:0] compare_b_value_o,    // compare b value
  output logic      [15:0] capture_value_o,      // capture / top value
  output logic             match_a_o,            // compare match a event
  output logic             match_b_o,            // compare match b event
  output logic             forced_a_o,           // match a came from strobe
  output logic             forced_b_o,           // match b came from strobe
  output logic      [1:0]  forced_action_a_o,    // action held with strobe a
  output logic      [1:0]  forced_action_b_o,    // action held with strobe b
  output logic             capture_top_o,        // capture value serves as top
  output logic             irq_capture_o,        // capture interrupt request
  output logic             irq_compare_b_o,      // compare b interrupt request
  output logic             irq_compare_a_o,      // compare a interrupt request
  output logic             irq_overflow_o        // overflow interrupt request
);

  // elaboration check: byte pairing through one latch fits a 16-bit counter only
  if (CNT_W != 16) begin : g_width_check
    $error("tcr_regs serves only a 16-bit counter");
  end

  // reset release through two flops
  logic rst_meta_reg;
  logic rst_n;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // non-pwm modes are normal and the two clear-on-match modes
  function automatic logic is_non_pwm(input tcr_mode_t m);
    return (m == 4'h0) || (m == 4'h4) || (m == 4'hC);
  endfunction

  // capture register as top in modes 8, 10, 12 and 14
  function automatic logic is_capture_top(input tcr_mode_t m);
    return (m == 4'h8) || (m == 4'hA) || (m == 4'hC) || (m == 4'hE);
  endfunction

  tcr_word_t counter_value_reg;
  tcr_word_t compare_a_value_reg;
  tcr_word_t compare_b_value_reg;
  tcr_word_t capture_value_reg;
  tcr_byte_t high_latch_reg;
  tcr_byte_t timer_irq_mask_reg;
  tcr_byte_t timer_event_flags_reg;
  logic      match_block_reg;
  logic      force_a_reg;
  logic      force_b_reg;
  tcr_byte_t rdata_reg;

  logic      wr_cnt_low;
  logic      wr_force;
  logic      cap_top;
  logic      eq_a;
  logic      eq_b;
  logic      hit_a;
  logic      hit_b;
  logic      cap_hit;
  logic      top_hit;
  tcr_byte_t set_bits;
  tcr_byte_t clr_bits;

  assign wr_cnt_low = io_wr_i && (io_addr_i == `TCR_COUNT_LOW);
  assign wr_force   = io_wr_i && (io_addr_i == `TCR_FORCE);
  assign cap_top    = is_capture_top(waveform_mode_select_i); // RULE14

  // shared high-byte latch: high writes land here, low reads refill it
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      high_latch_reg <= `TCR_RESET_BYTE;
    end else if (io_wr_i && (io_addr_i == `TCR_CAPTURE_HIGH ||
                             io_addr_i == `TCR_CMP_B_HIGH ||
                             io_addr_i == `TCR_CMP_A_HIGH ||
                             io_addr_i == `TCR_COUNT_HIGH)) begin
      high_latch_reg <= io_wdata_i; // RULE8
    end else if (io_rd_i) begin
      if (io_addr_i == `TCR_CAPTURE_LOW) begin
        high_latch_reg <= capture_value_reg[15:8]; // RULE9
      end else if (io_addr_i == `TCR_CMP_B_LOW) begin
        high_latch_reg <= compare_b_value_reg[15:8];
      end else if (io_addr_i == `TCR_CMP_A_LOW) begin
        high_latch_reg <= compare_a_value_reg[15:8];
      end else if (io_addr_i == `TCR_COUNT_LOW) begin
        high_latch_reg <= counter_value_reg[15:8];
      end
    end
  end

  // compare values commit whole on the low-byte write
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      compare_a_value_reg <= `TCR_RESET_WORD;
      compare_b_value_reg <= `TCR_RESET_WORD;
    end else if (io_wr_i) begin
      if (io_addr_i == `TCR_CMP_A_LOW) begin
        compare_a_value_reg <= {high_latch_reg, io_wdata_i}; // RULE6
      end else if (io_addr_i == `TCR_CMP_B_LOW) begin
        compare_b_value_reg <= {high_latch_reg, io_wdata_i}; // RULE9
      end
    end
  end

  // capture: pin events are ignored while the value serves as top
  assign cap_hit = capture_event_i && !cap_top; // RULE22
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      capture_value_reg <= `TCR_RESET_WORD;
    end else if (io_wr_i && io_addr_i == `TCR_CAPTURE_LOW) begin
      capture_value_reg <= {high_latch_reg, io_wdata_i};
    end else if (cap_hit) begin
      capture_value_reg <= counter_value_reg; // RULE13
    end
  end

  // live counter; a cpu write wins over the tick in the same cycle
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      counter_value_reg <= `TCR_RESET_WORD;
    end else if (wr_cnt_low) begin
      counter_value_reg <= {high_latch_reg, io_wdata_i}; // RULE7
    end else if (timer_tick_i) begin
      if (count_clear_i) begin
        counter_value_reg <= `TCR_RESET_WORD;
      end else if (count_down_i) begin
        counter_value_reg <= counter_value_reg - 16'h0001;
      end else begin
        counter_value_reg <= counter_value_reg + 16'h0001;
      end
    end
  end

  // after a counter write the next tick sees no compare match, since the
  // fresh value would otherwise fire on stale equality
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      match_block_reg <= 1'b0;
    end else if (wr_cnt_low) begin
      match_block_reg <= 1'b1; // RULE10
    end else if (timer_tick_i) begin
      match_block_reg <= 1'b0;
    end
  end

  // continuous equality, qualified by the tick and the write block
  assign eq_a    = (counter_value_reg == compare_a_value_reg); // RULE12
  assign eq_b    = (counter_value_reg == compare_b_value_reg);
  assign hit_a   = timer_tick_i && eq_a && !match_block_reg && !wr_cnt_low;
  assign hit_b   = timer_tick_i && eq_b && !match_block_reg && !wr_cnt_low;
  assign top_hit = timer_tick_i && cap_top &&
                   (counter_value_reg == capture_value_reg); // RULE21

  // force strobes: one-cycle pulses, never stored for readback
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      force_a_reg       <= 1'b0;
      force_b_reg       <= 1'b0;
      forced_action_a_o <= 2'h0;
      forced_action_b_o <= 2'h0;
    end else begin
      force_a_reg <= wr_force && io_wdata_i[`TCR_FORCE_A_BIT] &&
                     is_non_pwm(waveform_mode_select_i); // RULE1
      force_b_reg <= wr_force && io_wdata_i[`TCR_FORCE_B_BIT] &&
                     is_non_pwm(waveform_mode_select_i);
      if (wr_force) begin
        forced_action_a_o <= compare_output_action_a_i; // RULE3
        forced_action_b_o <= compare_output_action_b_i;
      end
    end
  end

  // match events to the waveform unit; forced ones bypass the equality
  // and, unless a tick match coincides, are flagged so the waveform unit does not clear the counter
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      match_a_o  <= 1'b0;
      match_b_o  <= 1'b0;
      forced_a_o <= 1'b0;
      forced_b_o <= 1'b0;
    end else begin
      match_a_o  <= hit_a || force_a_reg; // RULE2
      match_b_o  <= hit_b || force_b_reg;
      forced_a_o <= force_a_reg && !hit_a; // RULE4
      forced_b_o <= force_b_reg && !hit_b;
    end
  end

  // flag set and clear terms; hardware set beats a clear in one cycle
  always_comb begin
    set_bits = `TCR_RESET_BYTE;
    set_bits[`TCR_CAPTURE_BIT] = cap_hit || top_hit;
    set_bits[`TCR_CMP_B_BIT]   = hit_b; // RULE19
    set_bits[`TCR_CMP_A_BIT]   = hit_a; // RULE4
    set_bits[`TCR_OVF_BIT]     = overflow_event_i;
    clr_bits = `TCR_RESET_BYTE;
    if (io_wr_i && io_addr_i == `TCR_FLAGS) begin
      clr_bits = io_wdata_i & `TCR_EVENT_MASK; // RULE20
    end
    clr_bits[`TCR_CAPTURE_BIT] = clr_bits[`TCR_CAPTURE_BIT] | irq_ack_i[3];
    clr_bits[`TCR_CMP_B_BIT]   = clr_bits[`TCR_CMP_B_BIT] | irq_ack_i[2];
    clr_bits[`TCR_CMP_A_BIT]   = clr_bits[`TCR_CMP_A_BIT] | irq_ack_i[1];
    clr_bits[`TCR_OVF_BIT]     = clr_bits[`TCR_OVF_BIT] | irq_ack_i[0];
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      timer_event_flags_reg <= `TCR_RESET_BYTE;
    end else begin
      timer_event_flags_reg <= ((timer_event_flags_reg & ~clr_bits) | set_bits)
                               & `TCR_EVENT_MASK;
    end
  end

  // interrupt mask, only the four enable bits are kept
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      timer_irq_mask_reg <= `TCR_RESET_BYTE;
    end else if (io_wr_i && io_addr_i == `TCR_MASK) begin
      timer_irq_mask_reg <= io_wdata_i & `TCR_EVENT_MASK;
    end
  end

  // read port; high-byte addresses return the shared latch
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= `TCR_RESET_BYTE;
    end else if (io_rd_i) begin
      if (io_addr_i == `TCR_CAPTURE_LOW) begin
        rdata_reg <= capture_value_reg[7:0];
      end else if (io_addr_i == `TCR_CMP_B_LOW) begin
        rdata_reg <= compare_b_value_reg[7:0];
      end else if (io_addr_i == `TCR_CMP_A_LOW) begin
        rdata_reg <= compare_a_value_reg[7:0];
      end else if (io_addr_i == `TCR_COUNT_LOW) begin
        rdata_reg <= counter_value_reg[7:0];
      end else if (io_addr_i == `TCR_CAPTURE_HIGH || io_addr_i == `TCR_CMP_B_HIGH ||
                   io_addr_i == `TCR_CMP_A_HIGH || io_addr_i == `TCR_COUNT_HIGH) begin
        rdata_reg <= high_latch_reg;
      end else if (io_addr_i == `TCR_FLAGS) begin
        rdata_reg <= timer_event_flags_reg;
      end else if (io_addr_i == `TCR_MASK) begin
        rdata_reg <= timer_irq_mask_reg;
      end else begin
        rdata_reg <= `TCR_RESET_BYTE; // RULE5
      end
    end
  end

  assign io_rdata_o        = rdata_reg;
  assign counter_value_o   = counter_value_reg;
  assign compare_a_value_o = compare_a_value_reg;
  assign compare_b_value_o = compare_b_value_reg;
  assign capture_value_o   = capture_value_reg;
  assign capture_top_o     = cap_top;

  // requests follow flag, enable and the global flag with no delay
  assign irq_capture_o   = global_irq_enable_i &&
    timer_irq_mask_reg[`TCR_CAPTURE_BIT] && timer_event_flags_reg[`TCR_CAPTURE_BIT]; // RULE15
  assign irq_compare_b_o = global_irq_enable_i &&
    timer_irq_mask_reg[`TCR_CMP_B_BIT] && timer_event_flags_reg[`TCR_CMP_B_BIT]; // RULE16
  assign irq_compare_a_o = global_irq_enable_i &&
    timer_irq_mask_reg[`TCR_CMP_A_BIT] && timer_event_flags_reg[`TCR_CMP_A_BIT]; // RULE17
  assign irq_overflow_o  = global_irq_enable_i &&
    timer_irq_mask_reg[`TCR_OVF_BIT] && timer_event_flags_reg[`TCR_OVF_BIT]; // RULE18

endmodule

`default_nettype wire

// ### tb/tcr_regs_assertions.sv
// port checker for the timer register block
// assumes binding to tcr_regs; raw reset gates every property
`timescale 1ns/1ns
`default_nettype none
module tcr_regs_assertions (
  input wire logic        clk_i,                     // io clock
  input wire logic        reset_n_i,                 // raw reset
  input wire logic [5:0]  io_addr_i,                 // address
  input wire logic        io_wr_i,                   // write
  input wire logic        io_rd_i,                   // read
  input wire logic [7:0]  io_wdata_i,                // write data
  input wire logic [7:0]  io_rdata_o,                // read data
  input wire logic        timer_tick_i,              // tick
  input wire logic [3:0]  waveform_mode_select_i,    // mode
  input wire logic [1:0]  compare_output_action_a_i, // action a
  input wire logic        overflow_event_i,          // overflow
  input wire logic        capture_event_i,           // capture edge
  input wire logic [3:0]  irq_ack_i,                 // acks
  input wire logic [15:0] counter_value_o,           // counter
  input wire logic [15:0] compare_a_value_o,         // compare a
  input wire logic [15:0] capture_value_o,           // capture
  input wire logic        match_a_o,                 // match a
  input wire logic        match_b_o,                 // match b
  input wire logic        forced_a_o,                // forced a
  input wire logic        forced_b_o,                // forced b
  input wire logic [1:0]  forced_action_a_o,         // held action a
  input wire logic        capture_top_o,             // capture is top
  input wire logic        irq_compare_a_o,           // irq a
  input wire logic        irq_overflow_o             // irq overflow
);
  logic nonpwm;
  logic cnt_wr;
  logic force_a;
  logic pend_reg;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // decoded helpers for the properties below
  assign nonpwm = waveform_mode_select_i inside {4'h0, 4'h4, 4'hC};
  assign cnt_wr = io_wr_i && io_addr_i == 6'h28;
  assign force_a = io_wr_i && io_addr_i == 6'h2C && io_wdata_i[7];
  // a counter write stays pending until a tick uses it up
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pend_reg <= 1'b0;
    end else if (cnt_wr) begin
      pend_reg <= 1'b1;
    end else if (timer_tick_i) begin
      pend_reg <= 1'b0;
    end
  end
  chk_force_taken: assert property (force_a && nonpwm |-> ##[1:2] (match_a_o && forced_a_o))
    else $error("forced match a missing");
  chk_force_pwm: assert property (force_a && !nonpwm |-> ##1 !forced_a_o ##1 !forced_a_o)
    else $error("force honoured in pwm mode");
  chk_force_action: assert property (io_wr_i && io_addr_i == 6'h2C
    |=> forced_action_a_o == $past(compare_output_action_a_i)) else $error("action not held");
  chk_force_zero: assert property (io_rd_i && io_addr_i == 6'h2C |=> io_rdata_o == 8'h00)
    else $error("force bits read nonzero");
  chk_count_write: assert property (cnt_wr |=> counter_value_o[7:0] == $past(io_wdata_i))
    else $error("counter low write lost");
  chk_match_a: assert property (timer_tick_i && !pend_reg && !cnt_wr
    && counter_value_o == compare_a_value_o |=> match_a_o && !forced_a_o) else $error("match a lost");
  chk_match_blocked: assert property (timer_tick_i && (pend_reg || cnt_wr)
    |=> !(match_a_o && !forced_a_o) && !(match_b_o && !forced_b_o)) else $error("match not blocked");
  chk_capture_copy: assert property (capture_event_i && !capture_top_o && !io_wr_i
    |=> capture_value_o == $past(counter_value_o)) else $error("capture copy wrong");
  chk_capture_off: assert property (capture_event_i && capture_top_o && !io_wr_i
    |=> $stable(capture_value_o)) else $error("capture taken while top");
  chk_top_modes: assert property (capture_top_o == (waveform_mode_select_i[3]
    && !waveform_mode_select_i[0])) else $error("top select wrong");
  chk_ack_clear: assert property (irq_ack_i[1] && !timer_tick_i && !$past(timer_tick_i)
    |=> !irq_compare_a_o) else $error("ack left irq a");
  chk_ovf_clear: assert property (irq_ack_i[0] && !overflow_event_i |=> !irq_overflow_o)
    else $error("ack left overflow irq");
  cov_force: cover property (force_a && nonpwm ##2 forced_a_o);
  cov_capture: cover property (capture_event_i && !capture_top_o);
  cov_match: cover property (timer_tick_i ##1 match_b_o);
endmodule
bind tcr_regs tcr_regs_assertions u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i),
  .io_rdata_o(io_rdata_o), .timer_tick_i(timer_tick_i),
  .waveform_mode_select_i(waveform_mode_select_i),
  .compare_output_action_a_i(compare_output_action_a_i), .overflow_event_i(overflow_event_i),
  .capture_event_i(capture_event_i), .irq_ack_i(irq_ack_i), .counter_value_o(counter_value_o),
  .compare_a_value_o(compare_a_value_o), .capture_value_o(capture_value_o),
  .match_a_o(match_a_o), .match_b_o(match_b_o), .forced_a_o(forced_a_o),
  .forced_b_o(forced_b_o), .forced_action_a_o(forced_action_a_o),
  .capture_top_o(capture_top_o), .irq_compare_a_o(irq_compare_a_o),
  .irq_overflow_o(irq_overflow_o));
`default_nettype wire

// ### tb/tcr_regs_tb_top.sv
// self-checking bench for the timer register block
// assumes the checker file is compiled first; inputs change on falling edges
`timescale 1ns/1ns
`default_nettype none
module tcr_regs_tb_top;
  import tcr_pkg::*;
  logic        clk, rst_n, wr, rd, tick, ovf, cap, gie, clr, dn;
  logic [5:0]  addr;
  logic [7:0]  wdata, rdata;
  logic [3:0]  mode, ack;
  logic [1:0]  act_a, act_b, fact_a, fact_b;
  logic [15:0] cnt, cmp_a, cmp_b, capv, d;
  logic        m_a, m_b, f_a, f_b, ctop, irq_c, irq_b, irq_a, irq_o;
  logic [63:0] all_v;
  int          bad_count = 0, n_compared = 0, nforce = 0, n0;
  tcr_regs dut (
    .clk_i(clk), .reset_n_i(rst_n), .io_addr_i(addr), .io_wr_i(wr), .io_rd_i(rd),
    .io_wdata_i(wdata), .io_rdata_o(rdata), .timer_tick_i(tick), .waveform_mode_select_i(mode),
    .compare_output_action_a_i(act_a), .compare_output_action_b_i(act_b),
    .count_clear_i(clr), .count_down_i(dn), .overflow_event_i(ovf),
    .capture_event_i(cap), .global_irq_enable_i(gie), .irq_ack_i(ack),
    .counter_value_o(cnt), .compare_a_value_o(cmp_a), .compare_b_value_o(cmp_b),
    .capture_value_o(capv), .match_a_o(m_a), .match_b_o(m_b), .forced_a_o(f_a),
    .forced_b_o(f_b), .forced_action_a_o(fact_a), .forced_action_b_o(fact_b),
    .capture_top_o(ctop), .irq_capture_o(irq_c), .irq_compare_b_o(irq_b),
    .irq_compare_a_o(irq_a), .irq_overflow_o(irq_o));
  assign all_v = {cnt, cmp_a, cmp_b, capv};
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // forced matches counted as they appear, since the pulse lasts one cycle
  always @(posedge clk) begin
    nforce += int'(m_a && f_a) + int'(m_b && f_b);
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // each access leaves one idle cycle so strobes never retrigger in one step
  task automatic wr8(input logic [5:0] a, input logic [7:0] v);
    @(negedge clk);
    addr = a;
    wdata = v;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rdc(input logic [5:0] a, input logic [15:0] e);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d = {8'h00, rdata};
    chk(d, e);
  endtask
  task automatic wr16(input logic [5:0] a, input logic [15:0] v);
    wr8(a + 6'h01, v[15:8]);
    wr8(a, v[7:0]);
  endtask
  task automatic rd16(input logic [5:0] a, input logic [15:0] e);
    rdc(a, {8'h00, e[7:0]});
    rdc(a + 6'h01, {8'h00, e[15:8]});
  endtask
  // one-cycle pulse on ack, capture, overflow and tick inputs
  task automatic strobe(input logic [6:0] m);
    @(negedge clk);
    {ack, cap, ovf, tick} = m;
    @(negedge clk);
    {ack, cap, ovf, tick} = 7'h00;
  endtask
  task automatic summarize;
    if (bad_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #100us;
    bad_count++;
    summarize();
  end
  initial begin
    {rst_n, wr, rd, tick, ovf, cap, gie, clr, dn, ack, addr, wdata, mode} = '0;
    {act_a, act_b} = 4'h0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    for (int i = 8'h22; i <= 8'h2C; i++) begin
      rdc(i[5:0], 16'h0000);
    end
    rdc(6'h10, 16'h0000);
    // each 16-bit value through the shared latch, also seen at its port
    for (int i = 0; i < 4; i++) begin
      wr16(6'h22 + 6'(2 * i), {8'hA0 + 8'(i), 8'h50 + 8'(i)});
      rd16(6'h22 + 6'(2 * i), {8'hA0 + 8'(i), 8'h50 + 8'(i)});
      chk(all_v[16 * i +: 16], {8'hA0 + 8'(i), 8'h50 + 8'(i)});
    end
    wr8(6'h27, 8'hAB);
    wr8(6'h24, 8'h01);
    chk(cmp_b, 16'hAB01);
    rdc(6'h28, 16'h0053);
    rdc(6'h27, 16'h00A3);
    wr8(6'h2B, 8'hFF);
    rdc(6'h2B, 16'h0027);
    // matches: the first tick after a counter write is blind
    wr16(6'h26, 16'h0020);
    wr16(6'h24, 16'h0021);
    wr16(6'h28, 16'h0020);
    strobe(7'h01);
    rdc(6'h2A, 16'h0000);
    strobe(7'h01);
    rdc(6'h2A, 16'h0004);
    wr16(6'h26, 16'h0022);
    strobe(7'h01);
    rdc(6'h2A, 16'h0006);
    chk(cnt, 16'h0023);
    gie = 1'b1;
    #1 chk({irq_c, irq_b, irq_a, irq_o}, 16'h0006);
    @(negedge clk) gie = 1'b0;
    #1 chk({irq_c, irq_b, irq_a, irq_o}, 16'h0000);
    strobe(7'h10);
    rdc(6'h2A, 16'h0004);
    wr8(6'h2A, 8'h04);
    rdc(6'h2A, 16'h0000);
    gie = 1'b1;
    strobe(7'h02);
    chk(irq_o, 16'h0001);
    strobe(7'h08);
    rdc(6'h2A, 16'h0000);
    strobe(7'h04);
    rd16(6'h22, 16'h0023);
    chk(irq_c, 16'h0001);
    wr8(6'h2A, 8'h20);
    // capture as top: pin ignored, flag follows counter reaching top
    mode = 4'hC;
    #1 chk(ctop, 16'h0001);
    wr16(6'h22, 16'h0024);
    strobe(7'h04);
    chk(capv, 16'h0024);
    rdc(6'h2A, 16'h0000);
    strobe(7'h01);
    strobe(7'h01);
    rdc(6'h2A, 16'h0020);
    wr8(6'h2A, 8'h20);
    // force strobes in three non-pwm and two pwm modes, every action code
    for (int i = 0; i < 5; i++) begin
      mode = i == 0 ? 4'h0 : i == 1 ? 4'h4 : i == 2 ? 4'hC : i == 3 ? 4'h1 : 4'h5;
      act_a = 2'(i);
      act_b = ~2'(i);
      n0 = nforce;
      wr8(6'h2C, 8'hC0);
      rdc(6'h2C, 16'h0000);
      chk(16'(nforce - n0), i < 3 ? 16'h0002 : 16'h0000);
      chk({fact_a, fact_b}, {12'h000, 2'(i), ~2'(i)});
      rdc(6'h2A, 16'h0000);
      chk(cnt, 16'h0025);
    end
    // waveform unit steering: clear at a tick, then count down through zero
    {clr, dn} = 2'b10;
    strobe(7'h01);
    chk(cnt, 16'h0000);
    {clr, dn} = 2'b01;
    strobe(7'h01);
    chk(cnt, 16'hFFFF);
    dn = 1'b0;
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk(cnt, 16'h0000);
    rd16(6'h26, 16'h0000);
    summarize();
  end
endmodule
`default_nettype wire
